/* File: dacc_control.v */
// Dual-channel 8-bit converter control: registers, enables, conversion timing.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "dacc_consts.vh"

module dacc_control #(
  parameter CONV_CYCLES = `DACC_CONV_CYCLES
) (
  input  wire        ref_clk,      // System clock, 100 MHz.
  input  wire        sys_rst,      // Synchronous active-high reset.
  input  wire        hwStandby,    // Hardware standby, initialises like reset.
  input  wire        swStandby,    // Software standby request from the system.
  input  wire [3:0]  busAddr,      // Register index.
  input  wire [15:0] busWdata,     // Write data.
  input  wire        busWr,        // Write strobe.
  input  wire        busRd,        // Read strobe.
  output reg  [15:0] busRdata,     // Read data, valid the cycle after busRd.
  output reg  [7:0]  ch0Level,     // Code presented to channel 0 analog stage.
  output reg  [7:0]  ch1Level,     // Code presented to channel 1 analog stage.
  output reg         ch0PinOe,     // Channel 0 pin drives when high.
  output reg         ch1PinOe,     // Channel 1 pin drives when high.
  output reg         ch0Valid,     // Channel 0 result has settled.
  output reg         ch1Valid,     // Channel 1 result has settled.
  output reg         ch0Convert,   // Channel 0 converter active.
  output reg         ch1Convert,   // Channel 1 converter active.
  output reg         converterStop // Module stop state.
);

  localparam CW = 20;
  localparam integer  CONV_M1   = CONV_CYCLES - 1;
  localparam [CW-1:0] CONV_LAST = CONV_M1[CW-1:0];

  reg  [7:0]    ch0_data;
  reg  [7:0]    ch1_data;
  reg           ch0_output_enable;
  reg           ch1_output_enable;
  reg           conversion_combine;
  reg  [15:0]   module_stop_control;
  reg  [CW-1:0] cnt0;
  reg  [CW-1:0] cnt1;
  reg           busy0;
  reg           busy1;
  reg           oe0Prev;
  reg           oe1Prev;

  wire          initNow  = sys_rst | hwStandby;
  wire          stopped  = module_stop_control[`DACC_BIT_STOP];
  wire          regWr    = busWr & ~stopped;
  wire          regRd    = busRd & ~stopped;
  wire          ctrlWr   = regWr & (busAddr == `DACC_OFF_CTRL);
  wire          d0Wr     = regWr & (busAddr == `DACC_OFF_CH0_DATA);
  wire          d1Wr     = regWr & (busAddr == `DACC_OFF_CH1_DATA);
  wire          mstopWr  = busWr & (busAddr == `DACC_OFF_MSTOP);
  wire          anyOe    = ch0_output_enable | ch1_output_enable;
  // Combine bit couples conversion only; pin drive stays per channel.
  wire          conv0En  = ~stopped & (ch0_output_enable | (conversion_combine & anyOe));
  wire          conv1En  = ~stopped & (ch1_output_enable | (conversion_combine & anyOe));
  wire          start0   = conv0En & (d0Wr | (ch0_output_enable & ~oe0Prev));
  wire          start1   = conv1En & (d1Wr | (ch1_output_enable & ~oe1Prev));
  wire [7:0]    ctrlRead = {ch1_output_enable, ch0_output_enable, conversion_combine, 5'h1F};

  // Register file; module stop register is reachable even when stopped.
  // Software standby touches nothing here, so state is held through it.
  always @(posedge ref_clk) begin
    if (initNow) begin
      ch0_data            <= `DACC_DATA_RESET;
      ch1_data            <= `DACC_DATA_RESET;
      ch0_output_enable   <= 1'b0;
      ch1_output_enable   <= 1'b0;
      conversion_combine  <= 1'b0;
      module_stop_control <= `DACC_MSTOP_RESET;
    end else begin
      if (d0Wr) begin
        ch0_data <= busWdata[7:0];
      end
      if (d1Wr) begin
        ch1_data <= busWdata[7:0];
      end
      if (ctrlWr) begin
        ch1_output_enable  <= busWdata[`DACC_BIT_OE1];
        ch0_output_enable  <= busWdata[`DACC_BIT_OE0];
        conversion_combine <= busWdata[`DACC_BIT_COMBINE];  // Low bits dropped.
      end
      if (mstopWr) begin
        module_stop_control <= busWdata;
      end
    end
  end

  // Read path, one cycle latency; stopped reads other than module stop, and unmapped reads, return zero.
  always @(posedge ref_clk) begin
    if (initNow) begin
      busRdata <= 16'h0000;
    end else if (busRd) begin
      if (busAddr == `DACC_OFF_MSTOP) begin
        busRdata <= module_stop_control;
      end else if (!regRd) begin
        busRdata <= 16'h0000;
      end else if (busAddr == `DACC_OFF_CTRL) begin
        busRdata <= {8'h00, ctrlRead};
      end else if (busAddr == `DACC_OFF_CH0_DATA) begin
        busRdata <= {8'h00, ch0_data};
      end else if (busAddr == `DACC_OFF_CH1_DATA) begin
        busRdata <= {8'h00, ch1_data};
      end else begin
        busRdata <= 16'h0000;
      end
    end else begin
      busRdata <= 16'h0000;
    end
  end

  // Conversion timing per channel; one conversion per start, then idle with result valid until the next start or until the channel's conversion is disabled.
  always @(posedge ref_clk) begin
    if (initNow) begin
      cnt0 <= {CW{1'b0}};
      cnt1 <= {CW{1'b0}};
      busy0 <= 1'b0;
      busy1 <= 1'b0;
      ch0Valid <= 1'b0;
      ch1Valid <= 1'b0;
      ch0Level <= 8'h00;
      ch1Level <= 8'h00;
      oe0Prev <= 1'b0;
      oe1Prev <= 1'b0;
    end else begin
      oe0Prev <= ch0_output_enable & ~stopped;
      oe1Prev <= ch1_output_enable & ~stopped;
      if (!conv0En) begin
        busy0 <= 1'b0;
        ch0Valid <= 1'b0;
        cnt0 <= {CW{1'b0}};
      end else if (start0) begin
        busy0 <= 1'b1;
        ch0Valid <= 1'b0;
        cnt0 <= {CW{1'b0}};
      end else if (busy0) begin
        if (cnt0 == CONV_LAST) begin
          busy0 <= 1'b0;
          ch0Valid <= 1'b1;
          ch0Level <= ch0_data;  // Code times Vref over 256.
        end else begin
          cnt0 <= cnt0 + 1'b1;
        end
      end else if (!ch0Valid) begin
        busy0 <= 1'b1;  // Combine-enabled channel starts too.
      end
      if (!conv1En) begin
        busy1 <= 1'b0;
        ch1Valid <= 1'b0;
        cnt1 <= {CW{1'b0}};
      end else if (start1) begin
        busy1 <= 1'b1;
        ch1Valid <= 1'b0;
        cnt1 <= {CW{1'b0}};
      end else if (busy1) begin
        if (cnt1 == CONV_LAST) begin
          busy1 <= 1'b0;
          ch1Valid <= 1'b1;
          ch1Level <= ch1_data;
        end else begin
          cnt1 <= cnt1 + 1'b1;
        end
      end else if (!ch1Valid) begin
        busy1 <= 1'b1;
      end
      // Level stays until the next conversion completes.
    end
  end

  // Pin and status outputs; software standby does not release them.
  always @(posedge ref_clk) begin
    if (initNow) begin
      ch0PinOe <= 1'b0;
      ch1PinOe <= 1'b0;
      ch0Convert <= 1'b0;
      ch1Convert <= 1'b0;
      converterStop <= 1'b1;
    end else begin
      ch0PinOe <= ch0_output_enable & ~stopped;
      ch1PinOe <= ch1_output_enable & ~stopped;
      ch0Convert <= conv0En;
      ch1Convert <= conv1En;
      converterStop <= stopped;
    end
  end

endmodule

/* File: dacc_consts.vh */
// Constants for the dual-channel converter control block.
`ifndef DACC_CONSTS_VH
`define DACC_CONSTS_VH
`define DACC_ADDR_W        4
`define DACC_OFF_CH0_DATA  4'h4
`define DACC_OFF_CH1_DATA  4'h5
`define DACC_OFF_CTRL      4'h6
`define DACC_OFF_MSTOP     4'hC
`define DACC_CTRL_RESET    8'h1F
`define DACC_CTRL_FIXED    8'h1F
`define DACC_BIT_OE1       7
`define DACC_BIT_OE0       6
`define DACC_BIT_COMBINE   5
`define DACC_MSTOP_RESET   16'h3FFF
`define DACC_BIT_STOP      10
`define DACC_DATA_RESET    8'h00
`define DACC_CONV_TIME_NS  10000
`define DACC_CLK_PERIOD_NS 10
`define DACC_CONV_CYCLES   (`DACC_CONV_TIME_NS / `DACC_CLK_PERIOD_NS)
`endif

/* File: dacc_cpu_model.sv */
// Processor-side bus master model for the converter control block.
`timescale 1ns/1ps
module dacc_cpu_model (
  input  wire        ref_clk,  // Clock.
  input  wire [15:0] busRdata, // Read data.
  output reg  [3:0]  busAddr,  // Index.
  output reg  [15:0] busWdata, // Write data.
  output reg         busWr,    // Write strobe.
  output reg         busRd     // Read strobe.
);
  initial begin
    busAddr = 4'h0;
    busWdata = 16'h0000;
    busWr = 1'b0;
    busRd = 1'b0;
  end
  task wr(input [3:0] a, input [15:0] d);
    @(posedge ref_clk);
    busAddr <= a;
    busWdata <= d;
    busWr <= 1'b1;
    @(posedge ref_clk);
    busWr <= 1'b0;
  endtask
  task rd(input [3:0] a, output [15:0] d);
    @(posedge ref_clk);
    busAddr <= a;
    busRd <= 1'b1;
    @(posedge ref_clk);
    busRd <= 1'b0;
    #1 d = busRdata;
  endtask
endmodule

/* File: dacc_control_properties.sv */
// Port assertions for the converter control block.
`timescale 1ns/1ps
module dacc_control_properties #(parameter CONV_CYCLES = 4) (
  input wire        ref_clk, sys_rst, hwStandby, swStandby, // Clock, resets.
  input wire        busWr, busRd,                            // Strobes.
  input wire [3:0]  busAddr,                                 // Index.
  input wire [15:0] busWdata, busRdata,                      // Data.
  input wire [7:0]  ch0Level, ch1Level,                      // Codes.
  input wire        ch0PinOe, ch1PinOe, ch0Valid, ch1Valid,  // Pins.
  input wire        ch0Convert, ch1Convert, converterStop    // Activity.
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst || hwStandby);
  AST_HALT: assert property (converterStop [*2] |-> !(ch0Convert | ch1Convert | ch0PinOe))
    else $error("stopped block still active");
  AST_REFUSE: assert property (busRd && converterStop && !$past(busWr)
    && busAddr inside {4'h4, 4'h5, 4'h6} |=> busRdata == 16'h0000) else $error("refused read");
  AST_CTRL_ONES: assert property (busRd && busAddr == 4'h6 && !converterStop
    && !$past(busWr) |=> busRdata[4:0] == 5'h1F) else $error("fixed bits");
  AST_STOP_READ: assert property (busRd && busAddr == 4'hC && !$past(busWr)
    |=> busRdata[10] == $past(converterStop)) else $error("stop bit read");
  AST_PIN_CONV: assert property ((!ch0PinOe || ch0Convert) && (!ch1PinOe || ch1Convert))
    else $error("pin without conversion");
  AST_COMBINE: assert property (ch1Convert && !ch1PinOe |-> ch0PinOe)
    else $error("combine");
  AST_VALID: assert property ($rose(ch0Valid) |-> $past(ch0Convert, 2))
    else $error("early result");
  AST_HOLD: assert property (!$stable(ch0Level) |-> $rose(ch0Valid) || !ch0Convert)
    else $error("level changed");
  cover property (ch1Convert && !ch1PinOe);
  cover property ($rose(ch0Valid));
  cover property (busRd && converterStop);
endmodule
bind dacc_control dacc_control_properties #(.CONV_CYCLES(CONV_CYCLES)) dacc_control_properties_i (.*);

/* File: dacc_control_test.sv */
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module dacc_control_test;
  reg         ref_clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         hwStandby = 1'b0;
  reg         swStandby = 1'b0;
  wire [3:0]  busAddr;
  wire [15:0] busWdata, busRdata;
  wire [7:0]  ch0Level, ch1Level;
  wire        busWr, busRd, ch0PinOe, ch1PinOe, ch0Valid, ch1Valid;
  wire        ch0Convert, ch1Convert, converterStop;
  wire [15:0] stat = {ch1PinOe, ch1Convert, ch0PinOe, ch0Convert, ch1Valid, ch0Valid, 2'b00, ch0Level};
  integer     num_errors = 0, samples_checked = 0, cycles = 0, i, j;
  reg  [15:0] got;
  reg  [35:0] row;
  localparam [179:0] ROWS = {4'h3, 16'hFFFF, 16'h0000, 4'h6, 16'h0000, 16'h001F,
    4'h6, 16'h0020, 16'h003F, 4'h5, 16'h005A, 16'h005A, 4'h4, 16'h00A5, 16'h00A5};
  always #5 ref_clk = ~ref_clk;
  dacc_control #(.CONV_CYCLES(4)) dacc_control_i (.*);
  dacc_cpu_model dacc_cpu_model_i (.*);
  task chk(input [15:0] g, input [15:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task complete_run;
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task rd(input [3:0] a, input [15:0] e);
    dacc_cpu_model_i.rd(a, got);
    chk(got, e);
  endtask
  task waitFor(input both);
    for (j = 0; j < 20 && !(ch0Valid && (ch1Valid || !both)); j = j + 1) @(posedge ref_clk);
    #1;
  endtask
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(4'hC, 16'h3FFF);
    dacc_cpu_model_i.wr(4'h6, 16'h00C0);
    rd(4'h6, 16'h0000);
    dacc_cpu_model_i.wr(4'hC, 16'h3BFF);
    rd(4'h6, 16'h001F);
    rd(4'h4, 16'h0000);
    for (i = 0; i < 5; i = i + 1) begin
      row = ROWS[i*36 +: 36];
      dacc_cpu_model_i.wr(row[35:32], row[31:16]);
      rd(row[35:32], row[15:0]);
    end
    dacc_cpu_model_i.wr(4'h6, 16'h0040);
    waitFor(1'b0);
    chk(stat, 16'h34A5);
    @(posedge ref_clk) swStandby <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk(stat, 16'h34A5);
    @(posedge ref_clk) swStandby <= 1'b0;
    dacc_cpu_model_i.wr(4'h6, 16'h0060);
    waitFor(1'b1);
    chk(stat, 16'h7CA5);
    chk({8'h00, ch1Level}, 16'h005A);
    dacc_cpu_model_i.wr(4'h4, 16'h003C);
    @(posedge ref_clk);
    #1 chk({15'h0000, ch0Valid}, 16'h0000);
    waitFor(1'b1);
    chk(stat, 16'h7C3C);
    dacc_cpu_model_i.wr(4'h6, 16'h0020);
    repeat (2) @(posedge ref_clk);
    #1 chk({stat[15:12], 12'h000}, 16'h0000);
    dacc_cpu_model_i.wr(4'h6, 16'h0040);
    dacc_cpu_model_i.wr(4'hC, 16'h3FFF);
    repeat (2) @(posedge ref_clk);
    #1 chk({11'h000, converterStop, stat[15:12]}, 16'h0010);
    dacc_cpu_model_i.wr(4'h4, 16'h0011);
    dacc_cpu_model_i.wr(4'hC, 16'h3BFF);
    rd(4'h4, 16'h003C);
    dacc_cpu_model_i.wr(4'h6, 16'h0000);
    @(posedge ref_clk) swStandby <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk({stat[15:12], 12'h000}, 16'h0000);
    @(posedge ref_clk) swStandby <= 1'b0;
    @(posedge ref_clk) hwStandby <= 1'b1;
    @(posedge ref_clk) hwStandby <= 1'b0;
    rd(4'hC, 16'h3FFF);
    complete_run;
  end
endmodule
